// file: apb_master.sv
// apb requester standing in for the controller program
`timescale 1ns/1ps
module apb_master
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    logic ok;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold everything until ready is seen at an edge
    do
    begin
      @(posedge pclk);
      ok = pready;
      r = prdata;
    end
    while (ok !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so no signal is set twice in a step
    @(posedge pclk);
  endtask
endmodule

// file: bit_write_and_link_timing_config.sv
// request interpreter for single bit write and per-port link timing setup
//
// Overview of operation
// R1: accept bit write command per port
// R2: words 1-3 hold station, type, address
// R3: type 17 clears input, 22 toggles output
// R4: header byte 4 msb marks write
// R5: data block stx 0 0 etx check
// R6: programmable timing off in terminal protocol
// R7: accept set retries/timeouts per port
// R8: retries words 2-5, timeouts 1-5
// R9: hold four retry counts with ranges
// R10: hold five timeouts, min 50 ms
// R11: header-finish default follows data rate
// R12: program picks sane timeouts (far side)
// R13: refuse toggle on override tables
// R14: decode types 13..22 to table, op
// R15: out-of-range values rejected, error status
`timescale 1ns/1ps
module bit_write_and_link_timing_config
  import bitwr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ctl_e state_ff; // interpreter state
  ctl_e nxt_state;
  req_s req_ff; // request word block
  logic [1:0] status_ff; // last result
  logic [3:0] err_code_ff; // reason for error
  logic busy; // request in flight
  logic [3:0] cfg_ff; // bit0..1 terminal mode per port, bits 2..3 unused
  logic [2:0] rate_ff; // serial data rate code
  logic [31:0] hdr_ff; // header: station, byte4, address
  logic [39:0] data_ff; // data block bytes
  logic [5:0] retry_ff [2][4]; // per-port retry counts
  logic [3:0] to_sel_ff; // timeout read selector
  logic [15:0] to_rd; // timeout read data
  logic go_pulse; // software start strobe
  logic wr_acc; // apb write access phase
  logic rd_acc; // apb read access phase
  logic addr_ok; // decoded address exists
  logic is_bitwr; // command class flags
  logic is_retry;
  logic is_tmo;
  logic port_sel; // 0 = port 1, 1 = port 2
  bitop_s bop; // decoded memory type
  logic retry_ok; // retry values in range
  logic tmo_ok; // timeout values in range
  logic tmo_wr; // commit timeouts
  logic [15:0] tmo_w [5]; // timeout words in slot order
  logic [7:0] lrc; // block check char

  // apb handshake: zero wait states
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign go_pulse = wr_acc && (paddr == ADDR_GO) && pwdata[0];
  assign busy = (state_ff != S_IDLE);

  // address decode, unmapped answers slverr
  always_comb
  begin
    case (paddr)
      ADDR_CMD, ADDR_W1, ADDR_W2, ADDR_W3, ADDR_W4, ADDR_W5, ADDR_GO,
      ADDR_STAT, ADDR_CFG, ADDR_HDR, ADDR_DATA, ADDR_RETRY, ADDR_TOSEL,
      ADDR_TOVAL:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // request word block written by software while idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_ff <= '0;
    else if (wr_acc && !busy)
    begin
      case (paddr)
        ADDR_CMD: req_ff.cmd <= pwdata[15:0];
        ADDR_W1: req_ff.w1 <= pwdata[15:0];
        ADDR_W2: req_ff.w2 <= pwdata[15:0];
        ADDR_W3: req_ff.w3 <= pwdata[15:0];
        ADDR_W4: req_ff.w4 <= pwdata[15:0];
        ADDR_W5: req_ff.w5 <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // configuration and timeout selector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff <= 4'h0;
      rate_ff <= 3'h0;
      to_sel_ff <= 4'h0;
    end
    else if (wr_acc && paddr == ADDR_CFG)
    begin
      cfg_ff <= pwdata[3:0];
      rate_ff <= pwdata[6:4];
    end
    else if (wr_acc && paddr == ADDR_TOSEL)
      to_sel_ff <= pwdata[3:0];
  end

  // command classification
  assign is_bitwr = (req_ff.cmd == CMD_BITWR_P1) || (req_ff.cmd == CMD_BITWR_P2); // R1
  assign is_retry = (req_ff.cmd == CMD_RETRY_P1) || (req_ff.cmd == CMD_RETRY_P2); // R7
  assign is_tmo = (req_ff.cmd == CMD_TMO_P1) || (req_ff.cmd == CMD_TMO_P2); // R7
  assign port_sel = (req_ff.cmd == CMD_BITWR_P2) || (req_ff.cmd == CMD_RETRY_P2)
                    || (req_ff.cmd == CMD_TMO_P2);

  // memory type decode: table 0 in, 1 out, 2 in ovr, 3 out ovr; op 0 set 1 clr 2 tgl
  always_comb
  begin
    logic [6:0] mt;
    mt = req_ff.w2[6:0]; // R2
    bop = '0;
    if (req_ff.w2[15:7] != 9'h000 || mt < MT_SET_FIRST || mt > MT_LAST)
      bop.legal = 1'b0; // R14
    else if (mt >= MT_TGL_FIRST)
    begin
      // toggle exists only for plain input/output; 22 toggles output
      bop.table_sel = 2'(mt - MT_TGL_FIRST); // R3
      bop.op = 2'd2;
      bop.legal = 1'b1; // R13
    end
    else if (mt >= MT_CLR_FIRST)
    begin
      bop.table_sel = 2'(mt - MT_CLR_FIRST); // R3
      bop.op = 2'd1;
      bop.legal = 1'b1;
    end
    else
    begin
      bop.table_sel = 2'(mt - MT_SET_FIRST); // R14
      bop.op = 2'd0;
      bop.legal = 1'b1;
    end
  end

  // range checks; retry word 1 is ignored
  assign retry_ok = (req_ff.w2 <= RETRY_ENQ_MAX) && (req_ff.w3 <= RETRY_OTHER_MAX)
                    && (req_ff.w4 <= RETRY_OTHER_MAX) && (req_ff.w5 <= RETRY_OTHER_MAX); // R9
  assign tmo_ok = (req_ff.w1 >= TMO_MIN) && (req_ff.w1 <= TMO_MAX0)
                  && (req_ff.w2 >= TMO_MIN) && (req_ff.w2 <= TMO_MAX1)
                  && (req_ff.w3 >= TMO_MIN) && (req_ff.w3 <= TMO_MAX2)
                  && (req_ff.w4 >= TMO_MIN) && (req_ff.w4 <= TMO_MAX34)
                  && (req_ff.w5 >= TMO_MIN) && (req_ff.w5 <= TMO_MAX34); // R10

  // state sequencing
  always_comb
  begin
    case (state_ff)
      S_IDLE: nxt_state = go_pulse ? S_DEC : S_IDLE;
      S_DEC: nxt_state = S_EXEC;
      S_EXEC: nxt_state = S_DONE;
      S_DONE: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= S_IDLE;
    else
      state_ff <= nxt_state;
  end

  // execute: check, commit or reject, report status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= ST_IDLE;
      err_code_ff <= 4'h0;
    end
    else if (go_pulse && !busy)
      status_ff <= ST_IDLE;
    else if (state_ff == S_EXEC)
    begin
      if (is_bitwr && !bop.legal)
      begin
        status_ff <= ST_ERR; // R13
        err_code_ff <= 4'h1;
      end
      else if ((is_retry || is_tmo) && cfg_ff[port_sel])
      begin
        status_ff <= ST_ERR; // R6
        err_code_ff <= 4'h2;
      end
      else if ((is_retry && !retry_ok) || (is_tmo && !tmo_ok))
      begin
        status_ff <= ST_ERR; // R15
        err_code_ff <= 4'h3;
      end
      else if (is_bitwr || is_retry || is_tmo)
      begin
        status_ff <= ST_OK;
        err_code_ff <= 4'h0;
      end
      else
      begin
        status_ff <= ST_ERR;
        err_code_ff <= 4'h4;
      end
    end
  end

  // commit strobe for the timeout store u_tmo below; the retry store decodes its own
  assign tmo_wr = (state_ff == S_EXEC) && is_tmo && tmo_ok && !cfg_ff[port_sel]; // R15

  // retry store, defaults at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        retry_ff[p][0] <= RETRY_ENQ_DEF;
        for (int k = 1; k < 4; k++)
          retry_ff[p][k] <= RETRY_OTHER_DEF;
      end
    end
    else if (state_ff == S_EXEC && is_retry && retry_ok && !cfg_ff[port_sel]) // R6
    begin
      retry_ff[port_sel][0] <= req_ff.w2[5:0]; // R8
      retry_ff[port_sel][1] <= req_ff.w3[5:0];
      retry_ff[port_sel][2] <= req_ff.w4[5:0];
      retry_ff[port_sel][3] <= req_ff.w5[5:0];
    end
  end

  // timeout words in slot order, words 1 to 5
  assign tmo_w[0] = req_ff.w1; // R8
  assign tmo_w[1] = req_ff.w2;
  assign tmo_w[2] = req_ff.w3;
  assign tmo_w[3] = req_ff.w4;
  assign tmo_w[4] = req_ff.w5;

  timeout_mem u_tmo (
    .pclk(pclk),
    .presetn(presetn),
    .rate_code(rate_ff),
    .wr_en(tmo_wr),
    .wr_port(port_sel),
    .wr_w(tmo_w),
    .rd_idx(to_sel_ff),
    .rd_data(to_rd)
  );

  // block check char: xor of dummy payload and etx
  assign lrc = CH_DUMMY ^ CH_DUMMY ^ CH_ETX;

  // outgoing header and data block for a good bit write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdr_ff <= 32'h0000_0000;
      data_ff <= 40'h00_0000_0000;
    end
    else if (state_ff == S_EXEC && is_bitwr && bop.legal)
    begin
      hdr_ff <= {req_ff.w1[7:0], HDR_WR_FLAG | {1'b0, req_ff.w2[6:0]}, req_ff.w3}; // R4
      data_ff <= {CH_STX, CH_DUMMY, CH_DUMMY, CH_ETX, lrc}; // R5
    end
  end

  // read mux, registers read even while busy
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      case (paddr)
        ADDR_CMD: prdata = {16'h0000, req_ff.cmd};
        ADDR_W1: prdata = {16'h0000, req_ff.w1};
        ADDR_W2: prdata = {16'h0000, req_ff.w2};
        ADDR_W3: prdata = {16'h0000, req_ff.w3};
        ADDR_W4: prdata = {16'h0000, req_ff.w4};
        ADDR_W5: prdata = {16'h0000, req_ff.w5};
        ADDR_STAT: prdata = {25'h0, busy, err_code_ff, status_ff};
        ADDR_CFG: prdata = {25'h0, rate_ff, cfg_ff};
        ADDR_HDR: prdata = hdr_ff;
        ADDR_DATA: prdata = data_ff[31:0];
        ADDR_RETRY: prdata = {2'h0, retry_ff[to_sel_ff[0]][3], 2'h0,
                     retry_ff[to_sel_ff[0]][2], 2'h0, retry_ff[to_sel_ff[0]][1],
                     2'h0, retry_ff[to_sel_ff[0]][0]};
        ADDR_TOSEL: prdata = {28'h0, to_sel_ff};
        ADDR_TOVAL: prdata = {16'h0000, to_rd};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // go to done state takes exactly three cycles after the strobe
  property p_exec_timing;
    @(posedge pclk) disable iff (!presetn)
      go_pulse && !busy |-> ##1 state_ff == S_DEC ##1 state_ff == S_EXEC ##1 state_ff == S_DONE;
  endproperty
  a_exec_timing: assert property (p_exec_timing) else $error("sequence timing wrong"); // R1

  property p_hdr_flag;
    @(posedge pclk) disable iff (!presetn)
      state_ff == S_EXEC && is_bitwr && bop.legal
      |=> hdr_ff[23] && hdr_ff[22:16] == $past(req_ff.w2[6:0]);
  endproperty
  a_hdr_flag: assert property (p_hdr_flag) else $error("header byte 4 wrong"); // R4

  property p_data_block;
    @(posedge pclk) disable iff (!presetn)
      state_ff == S_EXEC && is_bitwr && bop.legal
      |=> data_ff == {8'h02, 8'h00, 8'h00, 8'h03, 8'h03};
  endproperty
  a_data_block: assert property (p_data_block) else $error("data block wrong"); // R5

  property p_rtu_keep;
    @(posedge pclk) disable iff (!presetn)
      state_ff == S_EXEC && (is_retry || is_tmo) && cfg_ff[port_sel]
      |=> status_ff == ST_ERR && !$past(tmo_wr) && $stable(retry_ff[port_sel][0]);
  endproperty
  a_rtu_keep: assert property (p_rtu_keep) else $error("terminal mode accepted timing"); // R6

  property p_ovr_toggle;
    @(posedge pclk) disable iff (!presetn)
      state_ff == S_EXEC && is_bitwr && req_ff.w2 > 16'd22
      |=> status_ff == ST_ERR && err_code_ff == 4'h1;
  endproperty
  a_ovr_toggle: assert property (p_ovr_toggle) else $error("bad type accepted"); // R13

  property p_clear_input;
    @(posedge pclk) disable iff (!presetn)
      req_ff.w2 == 16'd17 |-> bop.legal && bop.op == 2'd1 && bop.table_sel == 2'd0;
  endproperty
  a_clear_input: assert property (p_clear_input) else $error("type 17 decode wrong"); // R3

  property p_retry_range;
    @(posedge pclk) disable iff (!presetn)
      state_ff == S_EXEC && is_retry && req_ff.w3 > 16'd5
      |=> $stable(retry_ff[port_sel][1]) && status_ff == ST_ERR;
  endproperty
  a_retry_range: assert property (p_retry_range) else $error("bad retry stored"); // R15

  property p_tmo_min;
    @(posedge pclk) disable iff (!presetn)
      tmo_wr |-> req_ff.w1 >= 16'd50 && req_ff.w5 >= 16'd50 && req_ff.w5 <= 16'd65000;
  endproperty
  a_tmo_min: assert property (p_tmo_min) else $error("timeout out of range written"); // R10

endmodule

// file: bitwr_pkg.sv
// shared constants, types and register map for the request interpreter
package bitwr_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_W1 = 8'h04;
  localparam logic [7:0] ADDR_W2 = 8'h08;
  localparam logic [7:0] ADDR_W3 = 8'h0C;
  localparam logic [7:0] ADDR_W4 = 8'h10;
  localparam logic [7:0] ADDR_W5 = 8'h14;
  localparam logic [7:0] ADDR_GO = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_CFG = 8'h20;
  localparam logic [7:0] ADDR_HDR = 8'h24;
  localparam logic [7:0] ADDR_DATA = 8'h28;
  localparam logic [7:0] ADDR_RETRY = 8'h2C;
  localparam logic [7:0] ADDR_TOSEL = 8'h30;
  localparam logic [7:0] ADDR_TOVAL = 8'h34;

  // request command numbers
  localparam logic [15:0] CMD_BITWR_P1 = 16'd6110;
  localparam logic [15:0] CMD_BITWR_P2 = 16'd6210;
  localparam logic [15:0] CMD_RETRY_P1 = 16'd6130;
  localparam logic [15:0] CMD_RETRY_P2 = 16'd6230;
  localparam logic [15:0] CMD_TMO_P1 = 16'd6131;
  localparam logic [15:0] CMD_TMO_P2 = 16'd6231;

  // memory type codes for single bit write
  localparam logic [6:0] MT_SET_FIRST = 7'd13;
  localparam logic [6:0] MT_CLR_FIRST = 7'd17;
  localparam logic [6:0] MT_TGL_FIRST = 7'd21;
  localparam logic [6:0] MT_LAST = 7'd22;

  // header byte 4 layout
  localparam int HDR_WR_BIT = 7;
  localparam logic [7:0] HDR_WR_FLAG = 8'h80;

  // data block characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_DUMMY = 8'h00;
  localparam int DATA_LEN = 5;

  // retry ranges and defaults
  localparam logic [15:0] RETRY_ENQ_MAX = 16'd32;
  localparam logic [15:0] RETRY_OTHER_MAX = 16'd5;
  localparam logic [5:0] RETRY_ENQ_DEF = 6'd32;
  localparam logic [5:0] RETRY_OTHER_DEF = 6'd3;

  // timeout ranges and defaults in ms
  localparam logic [15:0] TMO_MIN = 16'd50;
  localparam logic [15:0] TMO_MAX0 = 16'd2000;
  localparam logic [15:0] TMO_MAX1 = 16'd3000;
  localparam logic [15:0] TMO_MAX2 = 16'd10000;
  localparam logic [15:0] TMO_MAX34 = 16'd65000;
  localparam logic [15:0] TMO_DEF0 = 16'd800;
  localparam logic [15:0] TMO_DEF2 = 16'd2000;
  localparam logic [15:0] TMO_DEF3 = 16'd2000;
  localparam logic [15:0] TMO_DEF4 = 16'd20000;

  // header-finish default per data-rate code (0 slowest .. 7 fastest)
  localparam logic [15:0] TMO_HDR_BY_RATE [8] = '{
    16'd3000, 16'd3000, 16'd2000, 16'd1500, 16'd1000, 16'd600, 16'd400, 16'd300};

  // status codes
  localparam logic [1:0] ST_IDLE = 2'h0;
  localparam logic [1:0] ST_OK = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;

  // interpreter states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DEC = 2'b01,
    S_EXEC = 2'b11,
    S_DONE = 2'b10
  } ctl_e;

  // decoded bit write target
  typedef struct packed {
    logic [1:0] table_sel;
    logic [1:0] op;
    logic legal;
  } bitop_s;

  // request word block
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic [15:0] w4;
    logic [15:0] w5;
  } req_s;

endpackage

// file: tb_top.sv
// self-checking bench for the request interpreter
`timescale 1ns/1ps
module tb_top
  import bitwr_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  integer seed;
  logic [33:0] exp_q [$]; // {check, slverr, data}
  logic [33:0] note;
  logic [15:0] dflt [5];
  logic [31:0] rnd;
  logic [15:0] t;
  logic [7:0] st;
  logic [15:0] ad;
  logic ok;

  bit_write_and_link_timing_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  apb_master m (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // 50 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // compare a read result against its note
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic final_report;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watcher: oldest note against each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[33])
        cmp(note[32:0], {pslverr, prdata});
    end
  end

  // hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    m.xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic se);
    logic [31:0] r;
    exp_q.push_back({1'b1, se, e});
    m.xfer(1'b0, a, 32'h0, r);
  endtask

  // load a request block, start it, wait for idle, check status
  task automatic run(input logic [15:0] c, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] d, input logic [15:0] e, input logic [15:0] f, input logic [31:0] s);
    logic [31:0] r;
    int n;
    wr(ADDR_CMD, {16'h0, c});
    wr(ADDR_W1, {16'h0, a});
    wr(ADDR_W2, {16'h0, b});
    wr(ADDR_W3, {16'h0, d});
    wr(ADDR_W4, {16'h0, e});
    wr(ADDR_W5, {16'h0, f});
    wr(ADDR_GO, 32'h1);
    n = 0;
    // poll busy with a bounded count; these reads are not judged
    do
    begin
      exp_q.push_back(34'h0);
      m.xfer(1'b0, ADDR_STAT, 32'h0, r);
      n++;
    end
    while (r[6] !== 1'b0 && n < 20);
    rd_chk(ADDR_STAT, s, 1'b0);
  endtask

  // timeout slot reads for one port
  task automatic tmo_chk(input int base, input logic [15:0] v [5]);
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_TOSEL, 32'(base + i));
      rd_chk(ADDR_TOVAL, {16'h0, v[i]}, 1'b0);
    end
  endtask

  initial
  begin
    presetn = 1'b0;
    seed = 83868;
    dflt = '{TMO_DEF0, TMO_HDR_BY_RATE[0], TMO_DEF2, TMO_DEF3, TMO_DEF4};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // defaults after reset
    wr(ADDR_TOSEL, 32'h0);
    rd_chk(ADDR_RETRY, 32'h03030320, 1'b0);
    tmo_chk(0, dflt);
    wr(ADDR_TOSEL, 32'h6);
    wr(ADDR_CFG, 32'h50);
    rd_chk(ADDR_TOVAL, {16'h0, TMO_HDR_BY_RATE[5]}, 1'b0);
    wr(ADDR_CFG, 32'h0);
    rd_chk(8'h3C, 32'h0, 1'b1);
    $display("test defaults done");
    // every memory type 12..24, ports alternating
    for (t = 16'd12; t <= 16'd24; t++)
    begin
      rnd = $random(seed);
      st = rnd[7:0];
      ad = rnd[31:16];
      ok = (t >= 16'd13 && t <= 16'd22);
      run(t[0] ? CMD_BITWR_P2 : CMD_BITWR_P1, {8'h0, st}, t, ad, rnd[15:0], rnd[23:8],
        ok ? 32'h1 : 32'h6);
      if (ok)
      begin
        rd_chk(ADDR_HDR, {st, 1'b1, t[6:0], ad}, 1'b0);
        rd_chk(ADDR_DATA, 32'h00000303, 1'b0);
      end
    end
    $display("test bit_write done");
    // terminal protocol on port 1 keeps fixed timing
    wr(ADDR_CFG, 32'h1);
    run(CMD_RETRY_P1, 16'h0, 16'd1, 16'd1, 16'd1, 16'd1, 32'h0A);
    run(CMD_TMO_P1, 16'd60, 16'd60, 16'd60, 16'd60, 16'd60, 32'h0A);
    wr(ADDR_CFG, 32'h0);
    // range edges; word 1 is ignored for retries
    rnd = $random(seed);
    run(CMD_RETRY_P2, rnd[15:0], 16'd32, 16'd5, 16'd0, 16'd5, 32'h1);
    run(CMD_RETRY_P2, 16'h0, 16'd33, 16'd1, 16'd1, 16'd1, 32'h0E);
    run(CMD_RETRY_P1, 16'h0, 16'd0, 16'd6, 16'd0, 16'd0, 32'h0E);
    wr(ADDR_TOSEL, 32'h1);
    rd_chk(ADDR_RETRY, 32'h05000520, 1'b0);
    wr(ADDR_TOSEL, 32'h0);
    rd_chk(ADDR_RETRY, 32'h03030320, 1'b0);
    $display("test retries done");
    // sane values at the range limits
    run(CMD_TMO_P1, 16'd2000, 16'd3000, 16'd10000, 16'd65000, 16'd50, 32'h1);
    run(CMD_TMO_P2, 16'd50, 16'd50, 16'd50, 16'd50, 16'd49, 32'h0E);
    run(CMD_TMO_P2, 16'd2001, 16'd50, 16'd50, 16'd50, 16'd50, 32'h0E);
    tmo_chk(0, '{16'd2000, 16'd3000, 16'd10000, 16'd65000, 16'd50});
    tmo_chk(5, dflt);
    run(16'd6111, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 32'h12);
    $display("test timeouts done");
    final_report();
  end
endmodule

// file: timeout_mem.sv
// small per-port timeout store with registered read data
`timescale 1ns/1ps
module timeout_mem
  import bitwr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] rate_code,
  input wire logic wr_en,
  input wire logic wr_port,
  input wire logic [15:0] wr_w [5],
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data
);

  logic [15:0] mem_ff [10]; // port*5 + slot
  logic [9:0] loaded_ff; // slot written since reset

  // writes replace all five slots of one port at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loaded_ff <= 10'h000;
    else if (wr_en)
      loaded_ff <= loaded_ff | (wr_port ? 10'h3E0 : 10'h01F);
  end

  genvar g;
  generate
    for (g = 0; g < 10; g++)
    begin : g_slot
      // storage only, no reset needed because defaults come from logic
      always_ff @(posedge pclk)
      begin
        if (wr_en && (wr_port == (g >= 5)))
          mem_ff[g] <= wr_w[g % 5];
      end
    end
  endgenerate

  // default table; header-finish default follows the data rate
  function automatic logic [15:0] def_of(input logic [2:0] slot, input logic [2:0] rc);
    case (slot)
      3'd0: def_of = TMO_DEF0;
      3'd1: def_of = TMO_HDR_BY_RATE[rc]; // R11
      3'd2: def_of = TMO_DEF2;
      3'd3: def_of = TMO_DEF3;
      default: def_of = TMO_DEF4;
    endcase
  endfunction

  // registered read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= 16'h0000;
    else if (rd_idx < 4'd10)
      rd_data <= loaded_ff[rd_idx] ? mem_ff[rd_idx]
                 : def_of(3'((rd_idx >= 4'd5) ? rd_idx - 4'd5 : rd_idx), rate_code);
    else
      rd_data <= 16'h0000;
  end

endmodule
